/* File: pkg/can_bt_pkg.sv */
// Package: register map, field layout, reset values and timing constants
// of the CAN bit-timing unit. Assumes an AXI4-Lite slave with 32-bit data.
package can_bt_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_TIMING_ZERO = 8'h00;
  localparam logic [7:0] OFS_TIMING_ONE = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // Timing register zero fields
  localparam int PRESC_LSB = 0;
  localparam int PRESC_W = 6;
  localparam int SJW_LSB = 6;
  localparam int SJW_W = 2;
  // Timing register one fields
  localparam int PH1_LSB = 0;
  localparam int PH1_W = 4;
  localparam int PH2_LSB = 4;
  localparam int PH2_W = 3;
  localparam int SMP_BIT = 7;
  // Control register fields
  localparam int INIT_BIT = 0;
  localparam int BUSOFF_BIT = 1;
  localparam int CDLO_BIT = 2;
  localparam int CDHI_BIT = 3;
  localparam int MULT_BIT = 4;
  localparam logic [7:0] TIMING_ZERO_RST = 8'h00;
  // Nonzero phases, so init mode is not forced off straight out of reset
  localparam logic [7:0] TIMING_ONE_RST = 8'h12;
  localparam logic [4:0] CONTROL_RST = 5'h01;
  // Clock-divide factor in half-oscillator-cycle units
  localparam logic [10:0] CCD_HALF = 11'h001;
  localparam logic [10:0] CCD_ONE = 11'h002;
  localparam logic [10:0] CCD_TWO = 11'h004;
  localparam logic [10:0] CCD_512 = 11'h400;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int SYNC_QUANTA = 1;
endpackage

/* File: rtl/can_bt_sampler.sv */
// Sampler: one or three samples ending at the sample point, majority vote.
// Assumes rx_i is already synchronised to clk_i.
`timescale 1ns/1ps
module can_bt_sampler (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic triple_i,
  input wire logic tq_tick_i,
  input wire logic sample_now_i,
  input wire logic rx_i,
  output logic bit_o,
  output logic bit_valid_o
);
  logic [1:0] hist_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hist_r <= 2'h3;
    end else if (ce_i && tq_tick_i) begin
      hist_r <= {hist_r[0], rx_i};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_o <= 1'b1;
      bit_valid_o <= 1'b0;
    end else if (ce_i) begin
      bit_valid_o <= sample_now_i;
      if (sample_now_i) begin
        if (triple_i) begin
          bit_o <= (hist_r[1] & hist_r[0]) | (hist_r[1] & rx_i) | (hist_r[0] & rx_i);
        end else begin
          bit_o <= rx_i;
        end
      end
    end
  end
endmodule // can_bt_sampler

/* File: rtl/can_bit_timing_unit.sv */
// CAN bit-timing unit: quantum prescaler, bit segment counter with
// resynchronisation, sampling, and AXI4-Lite timing registers.
// Assumes can_rx_i is asynchronous; bus-off comes from the protocol engine.
`timescale 1ns/1ps
module can_bit_timing_unit
  import can_bt_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic can_rst_i,
  input wire logic bus_off_i,
  input wire logic can_rx_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tq_tick_o,
  output logic sample_point_o,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic init_mode_o
);
  typedef enum logic [1:0] {SEG_SYNC, SEG_PH1, SEG_PH2} seg_t;

  // Software-side registers
  logic [7:0] can0_bus_timing_zero_r;
  logic [7:0] can0_bus_timing_one_r;
  logic init_mode_bit_r;
  logic clock_divide_lo_r;
  logic clock_divide_hi_r;
  logic clock_multiplier_select_r;
  // Engine-side copies
  logic [PRESC_W-1:0] prescaler_bits_r;
  logic [SJW_W-1:0] jump_width_bits_r;
  logic [PH1_W-1:0] phase1_len_field_r;
  logic [PH2_W-1:0] phase2_len_field_r;
  logic triple_sample_select_r;
  logic [10:0] ccd_r;
  // Synchronisers
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;
  logic canrst_meta_r;
  logic canrst_sync_r;
  logic busoff_meta_r;
  logic busoff_sync_r;
  // Quantum and segment counters
  logic [16:0] osc_cnt_r;
  logic [16:0] tq_period;
  logic tq_tick;
  logic [4:0] seg_cnt_r;
  logic [4:0] seg_cnt_nxt;
  seg_t seg_r;
  seg_t seg_nxt;
  logic [4:0] ph1_quanta;
  logic [4:0] ph2_quanta;
  logic [4:0] sjw_quanta;
  logic [4:0] ph1_end_r;
  logic [4:0] ph1_end_nxt;
  logic edge_fall;
  logic edge_seen_r;
  logic sample_now;
  // Bus slave
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic timing_wr_ok;

  // Two-stage synchronisers for pins and foreign-domain levels
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
      canrst_meta_r <= 1'b1;
      canrst_sync_r <= 1'b1;
      busoff_meta_r <= 1'b0;
      busoff_sync_r <= 1'b0;
    end else if (ce_i) begin
      rx_meta_r <= can_rx_i;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
      canrst_meta_r <= can_rst_i;
      canrst_sync_r <= canrst_meta_r;
      busoff_meta_r <= bus_off_i;
      busoff_sync_r <= busoff_meta_r;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = ce_i && !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = ce_i && !w_held_r && !s_axi_bvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign timing_wr_ok = init_mode_bit_r && !busoff_sync_r && !canrst_sync_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (awaddr_r)
          OFS_TIMING_ZERO, OFS_TIMING_ONE, OFS_CONTROL, OFS_STATUS: s_axi_bresp <= AXI_OKAY;
          default: s_axi_bresp <= AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Timing registers, guarded by init mode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      can0_bus_timing_zero_r <= TIMING_ZERO_RST;
      can0_bus_timing_one_r <= TIMING_ONE_RST;
    end else if (ce_i && do_write && wstrb_r[0] && timing_wr_ok) begin
      if (awaddr_r == OFS_TIMING_ZERO) begin
        can0_bus_timing_zero_r <= wdata_r[7:0];
      end
      if (awaddr_r == OFS_TIMING_ONE) begin
        can0_bus_timing_one_r <= wdata_r[7:0];
      end
    end
  end

  // Control register; init mode forced low on all-zero phase fields
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      init_mode_bit_r <= CONTROL_RST[INIT_BIT];
      clock_divide_lo_r <= CONTROL_RST[CDLO_BIT];
      clock_divide_hi_r <= CONTROL_RST[CDHI_BIT];
      clock_multiplier_select_r <= CONTROL_RST[MULT_BIT];
    end else if (ce_i) begin
      if (canrst_sync_r) begin
        init_mode_bit_r <= 1'b1;
      end else if (do_write && wstrb_r[0] && awaddr_r == OFS_CONTROL) begin
        init_mode_bit_r <= wdata_r[INIT_BIT];
        clock_divide_lo_r <= wdata_r[CDLO_BIT];
        clock_divide_hi_r <= wdata_r[CDHI_BIT];
        clock_multiplier_select_r <= wdata_r[MULT_BIT];
      end
      if (can0_bus_timing_one_r[PH1_LSB +: PH1_W] == '0
          && can0_bus_timing_one_r[PH2_LSB +: PH2_W] == '0) begin
        init_mode_bit_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = ce_i && !s_axi_rvalid;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= AXI_OKAY;
        unique case (s_axi_araddr)
          OFS_TIMING_ZERO: s_axi_rdata <= {24'h0, can0_bus_timing_zero_r};
          OFS_TIMING_ONE: s_axi_rdata <= {24'h0, can0_bus_timing_one_r};
          OFS_CONTROL: s_axi_rdata <= {27'h0, clock_multiplier_select_r, clock_divide_hi_r,
                                       clock_divide_lo_r, busoff_sync_r, init_mode_bit_r};
          OFS_STATUS: s_axi_rdata <= {27'h0, seg_r, rx_bit_o, rx_sync_r, triple_sample_select_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Engine copy loaded when a control write clears init mode; clock divide factor decode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prescaler_bits_r <= '0;
      jump_width_bits_r <= '0;
      phase1_len_field_r <= '0;
      phase2_len_field_r <= '0;
      triple_sample_select_r <= 1'b0;
      ccd_r <= CCD_ONE;
    end else if (ce_i && init_mode_bit_r && do_write && wstrb_r[0]
                 && awaddr_r == OFS_CONTROL && !wdata_r[INIT_BIT] && !canrst_sync_r) begin
      prescaler_bits_r <= can0_bus_timing_zero_r[PRESC_LSB +: PRESC_W];
      jump_width_bits_r <= can0_bus_timing_zero_r[SJW_LSB +: SJW_W];
      phase1_len_field_r <= can0_bus_timing_one_r[PH1_LSB +: PH1_W];
      phase2_len_field_r <= can0_bus_timing_one_r[PH2_LSB +: PH2_W];
      triple_sample_select_r <= can0_bus_timing_one_r[SMP_BIT];
      unique case ({wdata_r[CDHI_BIT], wdata_r[CDLO_BIT]})
        2'b00: ccd_r <= wdata_r[MULT_BIT] ? CCD_HALF : CCD_ONE;
        2'b10: ccd_r <= CCD_TWO;
        2'b11: ccd_r <= CCD_512;
        default: ccd_r <= CCD_ONE;
      endcase
    end
  end

  // Quantum = (prescaler+1) * factor oscillator periods; half-units base clock
  assign tq_period = 17'((prescaler_bits_r + 7'h01) * ccd_r);
  assign tq_tick = (osc_cnt_r >= tq_period - 17'h00001);
  assign tq_tick_o = tq_tick && !init_mode_bit_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_cnt_r <= '0;
    end else if (ce_i) begin
      if (init_mode_bit_r || tq_tick) begin
        osc_cnt_r <= '0;
      end else begin
        osc_cnt_r <= osc_cnt_r + 17'h00001;
      end
    end
  end

  // Segment lengths in quanta, field value plus one
  assign ph1_quanta = 5'(phase1_len_field_r) + 5'h01;
  assign ph2_quanta = 5'(phase2_len_field_r) + 5'h01;
  assign sjw_quanta = 5'(jump_width_bits_r) + 5'h01;
  assign edge_fall = edge_seen_r || (rx_prev_r && !rx_sync_r);

  always_comb begin
    seg_nxt = seg_r;
    seg_cnt_nxt = seg_cnt_r;
    ph1_end_nxt = ph1_end_r;
    if (tq_tick) begin
      seg_cnt_nxt = seg_cnt_r + 5'h01;
      unique case (seg_r)
        SEG_SYNC: begin
          seg_nxt = SEG_PH1;
          seg_cnt_nxt = 5'h00;
          ph1_end_nxt = ph1_quanta;
        end
        SEG_PH1: begin
          if (edge_fall) begin
            ph1_end_nxt = ph1_quanta + ((seg_cnt_r < sjw_quanta) ? seg_cnt_r : sjw_quanta);
          end
          if (seg_cnt_r + 5'h01 >= ph1_end_nxt) begin
            seg_nxt = SEG_PH2;
            seg_cnt_nxt = 5'h00;
          end
        end
        SEG_PH2: begin
          if (edge_fall || seg_cnt_r + 5'h01 >= ph2_quanta) begin
            seg_nxt = SEG_SYNC;
            seg_cnt_nxt = 5'h00;
          end
        end
        default: seg_nxt = SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seg_r <= SEG_SYNC;
      seg_cnt_r <= 5'h00;
      ph1_end_r <= 5'h00;
      edge_seen_r <= 1'b0;
    end else if (ce_i) begin
      if (init_mode_bit_r) begin
        seg_r <= SEG_SYNC;
        seg_cnt_r <= 5'h00;
        ph1_end_r <= 5'h00;
        edge_seen_r <= 1'b0;
      end else begin
        seg_r <= seg_nxt;
        seg_cnt_r <= seg_cnt_nxt;
        ph1_end_r <= ph1_end_nxt;
        edge_seen_r <= edge_fall && !tq_tick;
      end
    end
  end

  assign sample_now = !init_mode_bit_r && tq_tick && seg_r == SEG_PH1 && seg_nxt == SEG_PH2;
  assign sample_point_o = sample_now;
  assign init_mode_o = init_mode_bit_r;

  can_bt_sampler u_sampler (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .triple_i(triple_sample_select_r),
    .tq_tick_i(tq_tick && !init_mode_bit_r),
    .sample_now_i(sample_now),
    .rx_i(rx_sync_r),
    .bit_o(rx_bit_o),
    .bit_valid_o(rx_bit_valid_o)
  );
endmodule // can_bit_timing_unit

/* File: testbench/can_bt_monitor.sv */
// Checker: bus handshake and sampling relations at the top ports.
// Assumes one clock domain and sys_rst_i active high.
`timescale 1ns/1ps
module can_bt_monitor
  import can_bt_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic tq_tick_o,
  input wire logic sample_point_o,
  input wire logic rx_bit_valid_o,
  input wire logic init_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_no_bit_in_init: assert property (init_mode_o && $past(init_mode_o) |-> !rx_bit_valid_o)
    else $error("bit delivered in init mode");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
    |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_bit_follows: assert property (sample_point_o |=> rx_bit_valid_o)
    else $error("no bit after sample point");
  a_bit_cause: assert property (rx_bit_valid_o |-> $past(sample_point_o))
    else $error("bit without sample point");
  c_sample: cover property (sample_point_o);
  c_unmapped: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // can_bt_monitor

bind can_bit_timing_unit can_bt_monitor can_bt_monitor_inst (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .tq_tick_o(tq_tick_o), .sample_point_o(sample_point_o), .rx_bit_valid_o(rx_bit_valid_o),
  .init_mode_o(init_mode_o));

/* File: testbench/can_node_model.sv */
// Remote CAN node: recessive when idle, else alternating bits.
// Assumes period_i is the bit time in clk_i cycles.
`timescale 1ns/1ps
module can_node_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [15:0] period_i,
  output logic rx_o
);
  logic [15:0] cnt_r;
  initial begin
    cnt_r = 16'h0000;
    rx_o = 1'b1;
  end
  always @(posedge clk_i) begin
    if (!send_i) begin
      cnt_r <= 16'h0000;
      rx_o <= 1'b1;
    end else if (cnt_r == period_i - 16'h0001) begin
      cnt_r <= 16'h0000;
      rx_o <= !rx_o;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // can_node_model

/* File: testbench/tb_top.sv */
// Bench: drives registers over AXI4-Lite, measures quantum and bit timing.
// Assumes the remote node model on the receive pin.
`timescale 1ns/1ps
module tb_top
  import can_bt_pkg::*;
;
  logic clk_i, sys_rst_i, crst, bus_off_i, can_rx_i, send, prev, b, t1, t2;
  logic awv, wv, bv, br, arv, rr, awr, wr, arr, rv, tick, sp, bit_o, bit_v, init_o;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, rnd;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [15:0] period;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] e;
  int errors, num_checks, cycles, n, i;
  int tick_gap[4] = '{2, 4, 8, 2048};
  logic [7:0] ctl[4] = '{8'h10, 8'h00, 8'h08, 8'h0C};
  can_bit_timing_unit can_bit_timing_unit_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .can_rst_i(crst), .bus_off_i(bus_off_i), .can_rx_i(can_rx_i),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .tq_tick_o(tick), .sample_point_o(sp), .rx_bit_o(bit_o),
    .rx_bit_valid_o(bit_v), .init_mode_o(init_o));
  can_node_model can_node_model_inst (.clk_i(clk_i), .send_i(send), .period_i(period),
    .rx_o(can_rx_i));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hs(ref logic s);
    do begin
      @(negedge clk_i);
      t1 = s;
      @(posedge clk_i);
    end while (!t1);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_i);
      t1 = awr;
      t2 = wr;
      @(posedge clk_i);
      pa = pa && !t1;
      pw = pw && !t2;
      awv <= pa;
      wv <= pw;
    end
    repeat ($urandom % 3) @(posedge clk_i);
    br <= 1'b1;
    hs(bv);
    br <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    ara <= a;
    arv <= 1'b1;
    hs(arr);
    arv <= 1'b0;
    repeat ($urandom % 3) @(posedge clk_i);
    rr <= 1'b1;
    hs(rv);
    rr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic setup(input logic [7:0] z, input logic [7:0] o, input logic [7:0] c);
    wr_reg(OFS_CONTROL, 32'h1, AXI_OKAY);
    wr_reg(OFS_TIMING_ONE, {24'h0, o}, AXI_OKAY);
    wr_reg(OFS_TIMING_ZERO, {24'h0, z}, AXI_OKAY);
    wr_reg(OFS_CONTROL, {24'h0, c}, AXI_OKAY);
    rd_reg(OFS_CONTROL, {24'h0, c}, AXI_OKAY);
    rd_reg(OFS_TIMING_ONE, {24'h0, o}, AXI_OKAY);
  endtask
  task automatic gap(input logic s, output int k);
    k = 0;
    do @(posedge clk_i); while (!(s ? sp : tick));
    do begin
      @(posedge clk_i);
      k++;
    end while (!(s ? sp : tick));
  endtask
  task automatic next_bit();
    do @(posedge clk_i); while (!bit_v);
    b = bit_o;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      give_verdict();
    end
    if (rv && rr) begin
      e = rq.pop_front();
      check(rd, e[31:0]);
      check({30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (bv && br)
      check({30'h0, bresp}, {30'h0, bq.pop_front()});
  end
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    {sys_rst_i, crst, bus_off_i, send, awv, wv, br, arv, rr} = 9'h100;
    {awa, ara, wd, ws, period} = {8'h00, 8'h00, 32'h0, 4'hF, 16'h0018};
    void'($urandom(79));
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd_reg(OFS_CONTROL, 32'h1, AXI_OKAY);
    check({31'h0, init_o}, 32'h1);
    rd_reg(8'h10, 32'h0, AXI_SLVERR);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      setup(8'h01, 8'h12, ctl[i]);
      gap(1'b0, n);
      check(n, tick_gap[i]);
      gap(1'b1, n);
      check(n, 6 * tick_gap[i]);
    end
    $display("divider test done");
    rnd = $urandom;
    wr_reg(OFS_TIMING_ZERO, {rnd[31:8], 8'h3F}, AXI_OKAY);
    rd_reg(OFS_TIMING_ZERO, 32'h1, AXI_OKAY);
    wr_reg(OFS_CONTROL, 32'h1, AXI_OKAY);
    bus_off_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr_reg(OFS_TIMING_ZERO, {rnd[31:8], 8'h3F}, AXI_OKAY);
    rd_reg(OFS_TIMING_ZERO, 32'h1, AXI_OKAY);
    bus_off_i <= 1'b0;
    wr_reg(OFS_CONTROL, 32'h0, AXI_OKAY);
    crst <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr_reg(OFS_TIMING_ZERO, {rnd[31:8], 8'h3F}, AXI_OKAY);
    rd_reg(OFS_CONTROL, 32'h1, AXI_OKAY);
    rd_reg(OFS_TIMING_ZERO, 32'h1, AXI_OKAY);
    crst <= 1'b0;
    repeat (3) @(posedge clk_i);
    $display("lock test done");
    for (i = 0; i < 4; i++) begin
      setup(i[1] ? 8'h43 : 8'h41, i[1] ? 8'h92 : 8'h12, i[1] ? 8'h10 : 8'h00);
      period <= i[0] ? 16'h0016 : 16'h001A;
      send <= 1'b1;
      repeat (3) next_bit();
      prev = b;
      repeat (12) begin
        next_bit();
        check({31'h0, b}, {31'h0, ~prev});
        prev = b;
      end
      send <= 1'b0;
    end
    $display("resync test done");
    wr_reg(OFS_CONTROL, 32'h1, AXI_OKAY);
    wr_reg(OFS_TIMING_ONE, {rnd[31:8], 8'h80}, AXI_OKAY);
    rd_reg(OFS_CONTROL, 32'h0, AXI_OKAY);
    rd_reg(OFS_TIMING_ONE, 32'h80, AXI_OKAY);
    check({31'h0, init_o}, 32'h0);
    $display("zero guard test done");
    give_verdict();
  end
endmodule // tb_top
